// >>> verilog/spfs_pkg.sv
// package for the self-programming flash sequencer: register map, fields, timing
// assumes a 10 MHz system clock, a calibrated rc oscillator tick input, and a 32-bit apb master
package spfs_pkg;
    // register byte offsets
    localparam logic [7:0] SPFS_CTRL_OFS = 8'h00;
    localparam logic [7:0] SPFS_ZPTR_OFS = 8'h04;
    localparam logic [7:0] SPFS_DATA_OFS = 8'h08;
    localparam logic [7:0] SPFS_STORE_OFS = 8'h0c;
    localparam logic [7:0] SPFS_STAT_OFS = 8'h10;
    // control register fields
    localparam int SPFS_EN_BIT = 0;
    localparam int SPFS_ERASE_BIT = 1;
    localparam int SPFS_WRITE_BIT = 2;
    localparam int SPFS_LOCK_BIT = 3;
    localparam int SPFS_REEN_BIT = 4;
    localparam int SPFS_BUSY_BIT = 6;
    localparam logic [7:0] SPFS_CTRL_RST = 8'h00;
    // accepted command patterns
    localparam logic [4:0] SPFS_CMD_REEN = 5'h11;
    localparam logic [4:0] SPFS_CMD_LOCK = 5'h09;
    localparam logic [4:0] SPFS_CMD_WRITE = 5'h05;
    localparam logic [4:0] SPFS_CMD_ERASE = 5'h03;
    localparam logic [4:0] SPFS_CMD_FILL = 5'h01;
    // timing
    localparam int SPFS_ARM_CYCLES = 4;
    localparam int SPFS_RC_KHZ = 8000;
    localparam int SPFS_PROG_MIN_US = 3700;
    localparam int SPFS_PROG_MAX_US = 4500;
    localparam int SPFS_PROG_TICKS = (SPFS_PROG_MIN_US * SPFS_RC_KHZ + 999) / 1000;
    localparam int SPFS_STORE_LAT = 1;
    localparam logic [31:0] SPFS_DEVICE_ID = 32'h0000_5a5a;  // arbitrary value
    typedef enum logic [1:0] {
        SPFS_IDLE = 2'b00,
        SPFS_ARMED = 2'b01,
        SPFS_PROG = 2'b11
    } spfs_state_t;
endpackage

// >>> verilog/spfs_arm_timer.sv
// arm window counter for the self-programming enable
// assumes start and store are single-cycle pulses from the sequencer
`timescale 1ns/1ns
`default_nettype none
module spfs_arm_timer #(
    parameter int WINDOW = spfs_pkg::SPFS_ARM_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // control
    input wire logic start,
    input wire logic cancel,
    // status
    output logic expired
);
    import spfs_pkg::*;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (start)
            cnt_nxt = 4'(WINDOW);
        else if (cancel)
            cnt_nxt = 4'h0;
        else if (cnt_r != 4'h0)
            cnt_nxt = cnt_r - 4'h1;
    end
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            cnt_r <= 4'h0;
        else
            cnt_r <= cnt_nxt;
    end
    // window closes after the third cycle with no store
    // a store in the expiring cycle is refused, so expired must not depend on it
    assign expired = (cnt_r == 4'h1) && !start;
endmodule
`default_nettype wire

// >>> verilog/spfs_rc_timer.sv
// programming duration timer counting calibrated rc oscillator ticks
// assumes rcTick is a synchronous one-cycle pulse per rc oscillator period
`timescale 1ns/1ns
`default_nettype none
module spfs_rc_timer #(
    parameter int TICKS = spfs_pkg::SPFS_PROG_TICKS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic holdOnReset,
    // control
    input wire logic start,
    input wire logic rcTick,
    // status
    output logic running,
    output logic done
);
    import spfs_pkg::*;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic run_r;
    logic run_nxt;
    always_comb
    begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        if (start)
        begin
            cnt_nxt = 16'(TICKS);
            run_nxt = 1'b1;
        end
        else if (run_r && rcTick)
        begin
            cnt_nxt = cnt_r - 16'h1;
            if (cnt_r == 16'h1)
                run_nxt = 1'b0;
        end
    end
    always_ff @(posedge clk_sys)
    begin
        // a running write survives reset; an unknown run flag falls to the reset branch
        if (nrst || (holdOnReset && run_r))
        begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
        end
        else
        begin
            cnt_r <= 16'h0;
            run_r <= 1'b0;
        end
    end
    assign running = run_r;
    assign done = run_r && rcTick && (cnt_r == 16'h1);
endmodule
`default_nettype wire

// >>> verilog/spfs_sequencer.sv
// self-programming flash sequencer top with apb register access
// assumes synchronous inputs on clk_sys and a flash array that latches a command on flashStart
`timescale 1ns/1ns
`default_nettype none
module spfs_sequencer #(
    parameter bit RWW_SUPPORT = 1'b1,
    parameter int PAGE_WORDS = 32,
    parameter int ADDR_W = 16,
    parameter int PROG_TICKS = spfs_pkg::SPFS_PROG_TICKS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core and system state
    input wire logic powerDownSleep,
    input wire logic eepromWriteActive,
    input wire logic rcTick,
    input wire logic pageInRww,
    // flash array
    output logic flashStart,
    output logic [2:0] flashOp,
    output logic [ADDR_W-1:0] flashAddr,
    output logic [15:0] flashData,
    output logic bufWrite,
    output logic bufClear,
    output logic cpuHalt,
    output logic rwwBlocked
);
    import spfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state
    spfs_state_t state_r, state_nxt;
    logic [4:0] cmd_r, cmd_nxt;
    logic [ADDR_W-1:0] zPtr_r, zPtr_nxt;
    logic [15:0] data_r, data_nxt;
    logic busy_r, busy_nxt;
    logic halt_r, halt_nxt;
    logic flashStart_r, flashStart_nxt;
    logic [2:0] flashOp_r, flashOp_nxt;
    logic [ADDR_W-1:0] flashAddr_r, flashAddr_nxt;
    logic [15:0] flashData_r, flashData_nxt;
    logic bufWrite_r, bufWrite_nxt;
    logic bufClear_r, bufClear_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic armExpired, progRunning, progDone, timerStart, armStart, armCancel;

    logic wrAccess, rdAccess, ctrlWrite, storeWrite, cmdValid, writeBlocked;
    logic [4:0] wrCmd;

    function automatic logic spfs_cmd_ok(input logic [4:0] c);
        spfs_cmd_ok = (c == SPFS_CMD_REEN) || (c == SPFS_CMD_LOCK) || (c == SPFS_CMD_WRITE) ||
                      (c == SPFS_CMD_ERASE) || (c == SPFS_CMD_FILL);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    assign wrAccess = psel && penable && pwrite;
    assign rdAccess = psel && penable && !pwrite;
    assign wrCmd = pwdata[4:0];
    assign writeBlocked = powerDownSleep || eepromWriteActive;
    assign cmdValid = spfs_cmd_ok(wrCmd);
    assign ctrlWrite = wrAccess && (paddr == SPFS_CTRL_OFS) && cmdValid && !writeBlocked &&
                       (state_r == SPFS_IDLE);
    assign storeWrite = wrAccess && (paddr == SPFS_STORE_OFS) && (state_r == SPFS_ARMED) &&
                        !armExpired && !writeBlocked;
    assign armStart = ctrlWrite;
    assign armCancel = storeWrite;
    assign timerStart = storeWrite && (cmd_r == SPFS_CMD_ERASE || cmd_r == SPFS_CMD_WRITE ||
                                       cmd_r == SPFS_CMD_LOCK);
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb
    begin
        state_nxt = state_r;
        cmd_nxt = cmd_r;
        zPtr_nxt = zPtr_r;
        data_nxt = data_r;
        busy_nxt = busy_r;
        halt_nxt = halt_r;
        flashStart_nxt = 1'b0;
        flashOp_nxt = flashOp_r;
        flashAddr_nxt = flashAddr_r;
        flashData_nxt = flashData_r;
        bufWrite_nxt = 1'b0;
        bufClear_nxt = 1'b0;
        if (wrAccess && paddr == SPFS_ZPTR_OFS)
            zPtr_nxt = pwdata[ADDR_W-1:0];
        if (wrAccess && paddr == SPFS_DATA_OFS)
            data_nxt = pwdata[15:0];
        unique case (state_r)
            SPFS_IDLE:
            begin
                if (ctrlWrite)
                begin
                    cmd_nxt = wrCmd;
                    state_nxt = SPFS_ARMED;
                end
            end
            SPFS_ARMED:
            begin
                if (storeWrite)
                begin
                    flashAddr_nxt = zPtr_r;
                    flashData_nxt = data_r;
                    unique case (cmd_r)
                        SPFS_CMD_FILL:
                        begin
                            bufWrite_nxt = 1'b1;
                            flashAddr_nxt = {zPtr_r[ADDR_W-1:1], 1'b0};
                            cmd_nxt = 5'h00;
                            state_nxt = SPFS_IDLE;
                        end
                        SPFS_CMD_REEN:
                        begin
                            bufClear_nxt = 1'b1;
                            busy_nxt = 1'b0;
                            cmd_nxt = 5'h00;
                            state_nxt = SPFS_IDLE;
                        end
                        default:
                        begin
                            flashStart_nxt = 1'b1;
                            flashOp_nxt = cmd_r[3:1];
                            if (cmd_r != SPFS_CMD_LOCK)
                                busy_nxt = pageInRww;
                            halt_nxt = !pageInRww || cmd_r == SPFS_CMD_LOCK;
                            state_nxt = SPFS_PROG;
                        end
                    endcase
                end
                else if (armExpired)
                begin
                    cmd_nxt = 5'h00;
                    state_nxt = SPFS_IDLE;
                end
            end
            SPFS_PROG:
            begin
                // enable and command bits hold until the timer finishes
                if (progDone || !progRunning)
                begin
                    cmd_nxt = 5'h00;
                    halt_nxt = 1'b0;
                    state_nxt = SPFS_IDLE;
                end
            end
            default:
                state_nxt = SPFS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        // an unknown state at power-up falls to the reset branch
        if (nrst || (state_r == SPFS_PROG && progRunning))
        begin
            state_r <= state_nxt;
            cmd_r <= cmd_nxt;
            busy_r <= busy_nxt;
            halt_r <= halt_nxt;
        end
        else
        begin
            state_r <= SPFS_IDLE;
            cmd_r <= SPFS_CTRL_RST[4:0];
            busy_r <= 1'b0;
            halt_r <= 1'b0;
        end
        if (!nrst)
        begin
            zPtr_r <= '0;
            data_r <= 16'h0000;
            flashStart_r <= 1'b0;
            flashOp_r <= 3'h0;
            flashAddr_r <= '0;
            flashData_r <= 16'h0000;
            bufWrite_r <= 1'b0;
            bufClear_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            zPtr_r <= zPtr_nxt;
            data_r <= data_nxt;
            flashStart_r <= flashStart_nxt;
            flashOp_r <= flashOp_nxt;
            flashAddr_r <= flashAddr_nxt;
            flashData_r <= flashData_nxt;
            bufWrite_r <= bufWrite_nxt;
            bufClear_r <= bufClear_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, registered on the setup cycle so it stands during access
    always_comb
    begin
        prdata_nxt = prdata_r;
        if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                SPFS_CTRL_OFS:
                    prdata_nxt = {24'h0, 1'b0, busy_r & RWW_SUPPORT, 1'b0, cmd_r};
                SPFS_ZPTR_OFS:
                    prdata_nxt = 32'(zPtr_r);
                SPFS_DATA_OFS:
                    prdata_nxt = {16'h0, data_r};
                SPFS_STAT_OFS:
                    prdata_nxt = {28'h0, writeBlocked, halt_r, progRunning, state_r != SPFS_IDLE};
                default:
                    prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timers
    spfs_arm_timer #(.WINDOW(SPFS_ARM_CYCLES)) u_arm (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .start(armStart),
        .cancel(armCancel),
        .expired(armExpired)
    );

    spfs_rc_timer #(.TICKS(PROG_TICKS)) u_rc (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .holdOnReset(1'b1),
        .start(timerStart),
        .rcTick(rcTick),
        .running(progRunning),
        .done(progDone)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata = prdata_r;
    assign flashStart = flashStart_r;
    assign flashOp = flashOp_r;
    assign flashAddr = flashAddr_r;
    assign flashData = flashData_r;
    assign bufWrite = bufWrite_r;
    assign bufClear = bufClear_r;
    assign cpuHalt = halt_r;
    assign rwwBlocked = busy_r & RWW_SUPPORT;
endmodule
`default_nettype wire

// >>> testbench/spfs_sva.sv
// checker for the sequencer top: arm window, refusals, op codes, timing
// assumes rcTick pulses at most once a cycle and a synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module spfs_sva #(
    parameter int ADDR_W = 16,
    parameter int PROG_TICKS = 20
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    // system state
    input wire logic powerDownSleep,
    input wire logic eepromWriteActive,
    input wire logic rcTick,
    input wire logic pageInRww,
    // flash side
    input wire logic flashStart,
    input wire logic [2:0] flashOp,
    input wire logic [ADDR_W-1:0] flashAddr,
    input wire logic bufWrite,
    input wire logic bufClear,
    input wire logic cpuHalt,
    input wire logic rwwBlocked
);
    import spfs_pkg::*;
    logic ctrlWr;
    logic storeWr;
    logic anyPulse;
    int tickCnt_r;
    int tickCnt_nxt;
    assign ctrlWr = psel && penable && pwrite && paddr == SPFS_CTRL_OFS;
    assign storeWr = psel && penable && pwrite && paddr == SPFS_STORE_OFS;
    assign anyPulse = flashStart || bufWrite || bufClear;
    // rc ticks seen since the last op start, kept across reset
    always_comb
    begin
        tickCnt_nxt = tickCnt_r;
        if (flashStart)
            tickCnt_nxt = 0;
        else if (rcTick && tickCnt_r < 100000)
            tickCnt_nxt = tickCnt_r + 1;
    end
    always_ff @(posedge clk_sys)
    begin
        tickCnt_r <= tickCnt_nxt;
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_stored;
        $past(storeWr);
    endsequence
    sequence s_armed;
        $past(ctrlWr, 3) || $past(ctrlWr, 4);
    endsequence
    property p_window;
        anyPulse |-> s_stored ##0 s_armed;
    endproperty
    property p_sleep;
        anyPulse |-> !$past(powerDownSleep);
    endproperty
    property p_eeprom;
        anyPulse |-> !$past(eepromWriteActive);
    endproperty
    property p_op;
        flashStart |-> flashOp inside {3'h1, 3'h2, 3'h4};
    endproperty
    property p_dur;
        $fell(cpuHalt) |-> tickCnt_r >= PROG_TICKS - 1 && tickCnt_r <= PROG_TICKS + 1;
    endproperty
    property p_held;
        cpuHalt && tickCnt_r < PROG_TICKS - 2 |=> cpuHalt;
    endproperty
    property p_fill;
        bufWrite |-> !flashAddr[0];
    endproperty
    property p_clear;
        bufClear |-> !rwwBlocked;
    endproperty
    property p_sect;
        flashStart && flashOp != 3'h4 |-> cpuHalt == !$past(pageInRww) && rwwBlocked == $past(pageInRww);
    endproperty
    a_window: assert property (p_window) else $error("store outside arm window");
    a_sleep: assert property (p_sleep) else $error("store taken in sleep");
    a_eeprom: assert property (p_eeprom) else $error("store taken during eeprom write");
    a_op: assert property (p_op) else $error("bad flash op code");
    a_dur: assert property (p_dur) else $error("op length wrong");
    a_held: assert property (p_held) else $error("op ended early");
    a_fill: assert property (p_fill) else $error("fill address lsb set");
    a_clear: assert property (p_clear) else $error("busy kept after re-enable");
    a_sect: assert property (p_sect) else $error("halt or busy wrong for section");
endmodule
bind spfs_sequencer spfs_sva #(.ADDR_W(ADDR_W), .PROG_TICKS(PROG_TICKS)) i_spfs_sva (
    .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .powerDownSleep(powerDownSleep), .eepromWriteActive(eepromWriteActive),
    .rcTick(rcTick), .pageInRww(pageInRww), .flashStart(flashStart), .flashOp(flashOp),
    .flashAddr(flashAddr), .bufWrite(bufWrite), .bufClear(bufClear), .cpuHalt(cpuHalt),
    .rwwBlocked(rwwBlocked)
);
`default_nettype wire

// >>> testbench/spfs_flash_model.sv
// flash array model with the calibrated rc tick source
// assumes the sequencer pulses are one cycle wide on clk_sys
`timescale 1ns/1ns
`default_nettype none
module spfs_flash_model #(
    parameter int ADDR_W = 16
) (
    // clock and tick source
    input wire logic clk_sys,
    input wire logic tickOn,
    output logic rcTick,
    // sequencer side
    input wire logic flashStart,
    input wire logic [2:0] flashOp,
    input wire logic [ADDR_W-1:0] flashAddr,
    input wire logic [15:0] flashData,
    input wire logic bufWrite,
    input wire logic bufClear,
    // recorded traffic
    output int opCount,
    output int bufCount,
    output logic [2:0] lastOp,
    output logic [ADDR_W-1:0] lastAddr,
    output logic [15:0] lastData
);
    logic [1:0] div = 2'h0;
    always @(posedge clk_sys)
    begin
        div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
        rcTick <= tickOn && div == 2'h0;
        if (flashStart)
        begin
            opCount <= opCount + 1;
            lastOp <= flashOp;
            lastAddr <= flashAddr;
        end
        if (bufWrite)
        begin
            bufCount <= bufCount + 1;
            lastAddr <= flashAddr;
            lastData <= flashData;
        end
        if (bufClear)
            bufCount <= 0;
    end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the sequencer: apb master, random fill, ops, refusals
// assumes zero-wait apb and the flash model as far side
`timescale 1ns/1ns
`default_nettype none
module tb;
    import spfs_pkg::*;
    localparam int TICKS = 20;
    logic clk_sys, nrst, psel, penable, pwrite, powerDownSleep, eepromWriteActive, pageInRww, tickOn;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, rcTick, flashStart, bufWrite, bufClear, cpuHalt, rwwBlocked;
    logic [2:0] flashOp, lastOp;
    logic [15:0] flashAddr, flashData, lastAddr, lastData, z, d;
    int opCount, bufCount, expOps, bad_count, comparisons, i, n;
    logic [4:0] opCmd [3] = '{SPFS_CMD_ERASE, SPFS_CMD_WRITE, SPFS_CMD_LOCK};
    logic [2:0] opCode [3] = '{3'h1, 3'h2, 3'h4};
    spfs_sequencer #(.PROG_TICKS(TICKS)) i_spfs_sequencer (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .powerDownSleep(powerDownSleep),
        .eepromWriteActive(eepromWriteActive), .rcTick(rcTick), .pageInRww(pageInRww),
        .flashStart(flashStart), .flashOp(flashOp), .flashAddr(flashAddr), .flashData(flashData),
        .bufWrite(bufWrite), .bufClear(bufClear), .cpuHalt(cpuHalt), .rwwBlocked(rwwBlocked));
    spfs_flash_model i_spfs_flash_model (.clk_sys(clk_sys), .tickOn(tickOn), .rcTick(rcTick),
        .flashStart(flashStart), .flashOp(flashOp), .flashAddr(flashAddr), .flashData(flashData),
        .bufWrite(bufWrite), .bufClear(bufClear), .opCount(opCount), .bufCount(bufCount),
        .lastOp(lastOp), .lastAddr(lastAddr), .lastData(lastData));
    always #50 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (bad_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic give_up;
        bad_count++;
        complete_run();
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat, output logic [31:0] r);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
            if (k > 50)
                give_up();
        end while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        logic [31:0] r;
        apb(1'b1, a, dat, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h0, r);
    endtask
    task automatic idle_wait;
        logic [31:0] r;
        int k;
        k = 0;
        do
        begin
            rd(SPFS_CTRL_OFS, r);
            k++;
            if (k > 300)
                give_up();
        end while (r[SPFS_EN_BIT] !== 1'b0);
    endtask
    task automatic spm(input logic [4:0] cmd);
        idle_wait();
        wr(SPFS_CTRL_OFS, {27'h0, cmd});
        wr(SPFS_STORE_OFS, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        {clk_sys, nrst, psel, penable, pwrite, powerDownSleep, eepromWriteActive, pageInRww} = 8'h0;
        {tickOn, paddr, pwdata} = {1'b1, 8'h0, 32'h0};
        void'($urandom(32'h5187));
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(SPFS_CTRL_OFS, q);
        check(q, {24'h0, SPFS_CTRL_RST});
        z = 16'($urandom) & 16'hffc0;
        for (i = 0; i < 4; i++)
        begin
            d = 16'($urandom);
            wr(SPFS_ZPTR_OFS, {16'h0, z + 16'(2 * i + (i == 3))});
            wr(SPFS_DATA_OFS, {16'h0, d});
            spm(SPFS_CMD_FILL);
            repeat (2) @(posedge clk_sys);
            check(lastAddr, (z + 16'(2 * i)) & 16'hfffe);
            check(lastData, d);
        end
        wr(SPFS_CTRL_OFS, 32'h1);
        @(posedge clk_sys);
        wr(SPFS_STORE_OFS, 32'h0);
        rd(SPFS_CTRL_OFS, q);
        check(q, 32'h0);
        check(bufCount, 4);
        wr(8'h20, 32'hffffffff);
        rd(8'h20, q);
        check(q, 32'h0);
        check({pready, pslverr}, 32'h2);
        for (i = 0; i < 32; i++)
            if (!(5'(i) inside {SPFS_CMD_REEN, SPFS_CMD_LOCK, SPFS_CMD_WRITE, SPFS_CMD_ERASE, SPFS_CMD_FILL}))
            begin
                wr(SPFS_CTRL_OFS, i);
                wr(SPFS_STORE_OFS, 32'h0);
                rd(SPFS_CTRL_OFS, q);
                check(q, 32'h0);
            end
        for (i = 0; i < 2; i++)
        begin
            powerDownSleep <= (i == 0);
            eepromWriteActive <= (i == 1);
            wr(SPFS_CTRL_OFS, {27'h0, SPFS_CMD_ERASE});
            wr(SPFS_STORE_OFS, 32'h0);
            repeat (2) @(posedge clk_sys);
            check(opCount, expOps);
        end
        check(bufCount, 4);
        powerDownSleep <= 1'b0;
        eepromWriteActive <= 1'b0;
        for (i = 0; i < 3; i++)
        begin
            z = (i == 2) ? 16'hfffe : 16'($urandom) & 16'hffc0;
            pageInRww <= (i == 1);
            wr(SPFS_ZPTR_OFS, {16'h0, z});
            spm(opCmd[i]);
            expOps++;
            rd(SPFS_CTRL_OFS, q);
            check(q[7:0], {1'b0, i == 1, 1'b0, opCmd[i]});
            check(cpuHalt, i != 1);
            if (i == 0)
            begin
                tickOn <= 1'b0;
                repeat (40) @(posedge clk_sys);
                check(cpuHalt, 1'b1);
                tickOn <= 1'b1;
            end
            if (i == 2)
            begin
                nrst <= 1'b0;
                repeat (2) @(posedge clk_sys);
                nrst <= 1'b1;
                @(posedge clk_sys);
                check(cpuHalt, 1'b1);
            end
            idle_wait();
            check(cpuHalt, 1'b0);
            check(opCount, expOps);
            check(lastOp, opCode[i]);
            check(lastAddr, z);
            if (i == 1)
                spm(SPFS_CMD_REEN);
        end
        rd(SPFS_CTRL_OFS, q);
        check(q[SPFS_BUSY_BIT], 1'b0);
        pageInRww <= 1'b1;
        spm(SPFS_CMD_WRITE);
        idle_wait();
        rd(SPFS_CTRL_OFS, q);
        check(q[SPFS_BUSY_BIT], 1'b1);
        n = 0;
        while (q[SPFS_BUSY_BIT] !== 1'b0 && n < 4)
        begin
            spm(SPFS_CMD_REEN);
            rd(SPFS_CTRL_OFS, q);
            n++;
        end
        check(q[SPFS_BUSY_BIT], 1'b0);
        check(bufCount, 0);
        complete_run();
    end
endmodule
`default_nettype wire
